// *** core/prbs7_gen.sv ***
// Purpose: PRBS7 generator, x^7 + x^6 + 1, stepping on request
// Assumes: i_adv is synchronous to i_clk
// Notes:   Seed must be nonzero or the register locks up
`timescale 1ns/100ps
`default_nettype none
`include "tx_osm_params.svh"

module prbs7_gen (
   // Clock and reset
   input  wire logic       i_clk,
   input  wire logic       i_rst,
   // Control
   input  wire logic       i_adv,
   // State out
   output logic      [6:0] o_state
);

   tx_osm_pkg::prbs_state_t st_r;
   tx_osm_pkg::prbs_state_t st_nxt;

   // Shift one place per advance, feedback from taps 7 and 6
   always_comb begin
      st_nxt = st_r;
      if (i_adv) begin
         st_nxt.lfsr = {st_r.lfsr[5:0], st_r.lfsr[6] ^ st_r.lfsr[5]};
      end
   end

   // State register, nonzero seed at reset
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         st_r.lfsr <= `PRBS_SEED;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign o_state = st_r.lfsr;

endmodule
`default_nettype wire

// *** core/tx_osm_params.svh ***
// Purpose: Constants for the transmit ordered-set mapper
// Assumes: Code groups are carried as octets plus a control flag
// Notes:   Octet value of Dx.y and Kx.y is {y[2:0], x[4:0]}
`ifndef TX_OSM_PARAMS_SVH
`define TX_OSM_PARAMS_SVH

// ==========================================================
// Special and data code groups (octet form)
`define CG_K28_0     8'h1C
`define CG_K28_3     8'h7C
`define CG_K28_4     8'h9C
`define CG_K28_5     8'hBC
`define CG_K27_7     8'hFB
`define CG_K29_7     8'hFD
`define CG_K30_7     8'hFE
`define CG_K28_1     8'h3C
`define CG_K28_2     8'h5C
`define CG_K28_6     8'hDC
`define CG_K23_7     8'hF7
`define CG_D5_6      8'hC5
`define CG_D16_2     8'h50
`define CG_D21_5     8'hB5
`define CG_D2_2      8'h42

// ==========================================================
// Control characters on the XGMII side
`define XG_IDLE      8'h07
`define XG_SEQ       8'h9C
`define XG_START     8'hFB
`define XG_TERM      8'hFD
`define XG_ERROR     8'hFE

// ==========================================================
// Idle randomiser
`define PRBS_SEED    7'h7F
`define A_GAP_MIN    5'h10

`endif

// *** core/tx_osm_pkg.sv ***
// Purpose: Types for the transmit ordered-set mapper
// Assumes: Nothing beyond the constants header
// Notes:   Mode codes follow declaration order
package tx_osm_pkg;

   // ==========================================================
   // Protocol mode of the channel
   typedef enum logic [1:0] {
      MODE_BYPASS,
      MODE_PCIE,
      MODE_XAUI,
      MODE_GIGE
   } mode_t;

   // Gigabit Ethernet ordered-set tracker
   typedef enum logic {
      GS_NORMAL,
      GS_COMMA
   } gige_st_t;

   // Randomiser state
   typedef struct packed {
      logic [6:0] lfsr;
   } prbs_state_t;

   // Mapper state
   typedef struct packed {
      logic [7:0] data;
      logic       ctrl;
      logic       elec_idle;
      logic       det_go;
      logic       subst;
      gige_st_t   gst;
      logic [4:0] a_cnt;
   } tx_state_t;

endpackage

// *** core/tx_pcs_ordered_set_mapper.sv ***
// Purpose: Transmit ordered-set mapper ahead of the 8b/10b encoder
// Assumes: One character per clock, inputs synchronous to I_REF_CLK
// Notes:   One clock of latency from input character to output
`timescale 1ns/100ps
`default_nettype none
`include "tx_osm_params.svh"

module tx_pcs_ordered_set_mapper (
   // Clock and reset
   input  wire logic       I_REF_CLK,
   input  wire logic       I_RST,
   // Mode selection
   input  wire logic [1:0] I_MODE,
   // Character stream from the MAC or PCS
   input  wire logic [7:0] I_TXD,
   input  wire logic       I_TXC,
   input  wire logic       I_TERM_COL,
   // Encoder feedback
   input  wire logic       I_RD_POS,
   // PIPE controls
   input  wire logic       I_FORCE_ELEC_IDLE,
   input  wire logic       I_RX_DETECT_REQ,
   // Code group to the encoder
   output logic      [7:0] O_DATA,
   output logic            O_CTRL,
   output logic            O_SUBST,
   // Transmit buffer controls
   output logic            O_ELEC_IDLE,
   output logic            O_RX_DETECT_GO
);

   // ==========================================================
   // Decode functions

   // Control byte passed through as is: K28.0 to K28.3, K28.5, K28.6 or K23.7
   function automatic logic is_reserved(input logic [7:0] b);
      logic r;
      r = 1'b0;
      unique case (b)
         `CG_K28_0, `CG_K28_1, `CG_K28_2,
         `CG_K28_3, `CG_K28_5, `CG_K28_6,
         `CG_K23_7: r = 1'b1;
         default:   r = 1'b0;
      endcase
      return r;
   endfunction

   // Configuration data byte following a comma
   function automatic logic is_config(input logic [7:0] b);
      return (b == `CG_D21_5) || (b == `CG_D2_2);
   endfunction

   // Map a non-idle XGMII control byte to its code group
   function automatic logic [7:0] map_ctrl(input logic [7:0] b);
      logic [7:0] k;
      k = `CG_K30_7;
      unique case (b)
         `XG_SEQ:   k = `CG_K28_4;
         `XG_START: k = `CG_K27_7;
         `XG_TERM:  k = `CG_K29_7;
         `XG_ERROR: k = `CG_K30_7;
         default: begin
            if (is_reserved(b)) begin
               k = b;
            end else begin
               k = `CG_K30_7;
            end
         end
      endcase
      return k;
   endfunction

   // ==========================================================
   // State

   tx_osm_pkg::tx_state_t st_r;
   tx_osm_pkg::tx_state_t st_nxt;
   tx_osm_pkg::mode_t     mode;
   logic [6:0]            prbs;
   logic                  idle_adv;

   // Mode decode from the select pins
   assign mode = tx_osm_pkg::mode_t'(I_MODE);

   // ==========================================================
   // Idle randomiser

   // Steps once for each XAUI idle column
   prbs7_gen u_prbs (
      .i_clk   (I_REF_CLK),
      .i_rst   (I_RST),
      .i_adv   (idle_adv),
      .o_state (prbs)
   );

   // An idle character in XAUI mode advances the generator
   assign idle_adv = (mode == tx_osm_pkg::MODE_XAUI) && I_TXC &&
                     (I_TXD == `XG_IDLE);

   // ==========================================================
   // Next state

   // Per-mode character conversion
   always_comb begin
      st_nxt        = st_r;
      st_nxt.data   = I_TXD;
      st_nxt.ctrl   = I_TXC;
      st_nxt.subst  = 1'b0;
      st_nxt.gst    = tx_osm_pkg::GS_NORMAL;
      st_nxt.elec_idle = 1'b0;
      st_nxt.det_go    = 1'b0;

      unique case (mode)
         tx_osm_pkg::MODE_BYPASS: begin
            // Stream goes through untouched
            st_nxt.data = I_TXD;
            st_nxt.ctrl = I_TXC;
         end

         tx_osm_pkg::MODE_PCIE: begin
            // Characters pass; buffer may be idled
            if (I_FORCE_ELEC_IDLE) begin
               st_nxt.elec_idle = 1'b1;
               st_nxt.data      = 8'h00;
               st_nxt.ctrl      = 1'b0;
            end
            // Detection only starts on an idle buffer
            st_nxt.det_go = I_RX_DETECT_REQ &&
                            I_FORCE_ELEC_IDLE;
         end

         tx_osm_pkg::MODE_XAUI: begin
            if (!I_TXC) begin
               st_nxt.data = I_TXD;
               st_nxt.ctrl = 1'b0;
            end else if (I_TXD == `XG_IDLE) begin
               st_nxt.ctrl  = 1'b1;
               st_nxt.subst = 1'b1;
               // Gap counter runs on every idle group
               if (st_r.a_cnt != 5'h00) begin
                  st_nxt.a_cnt = st_r.a_cnt - 5'h01;
               end
               if (I_TERM_COL) begin
                  st_nxt.data = `CG_K28_5;
               end else if (st_r.a_cnt == 5'h00) begin
                  st_nxt.data  = `CG_K28_3;
                  st_nxt.a_cnt = `A_GAP_MIN + {1'b0, prbs[3:0]};
               end else if (prbs[6]) begin
                  st_nxt.data = `CG_K28_5;
               end else begin
                  st_nxt.data = `CG_K28_0;
               end
            end else begin
               st_nxt.data = map_ctrl(I_TXD);
               st_nxt.ctrl = 1'b1;
            end
         end

         tx_osm_pkg::MODE_GIGE: begin
            // Track comma so the following group can be judged
            if (I_TXC && (I_TXD == `CG_K28_5)) begin
               st_nxt.gst = tx_osm_pkg::GS_COMMA;
            end
            if ((st_r.gst == tx_osm_pkg::GS_COMMA) && !I_TXC) begin
               if (is_config(I_TXD)) begin
                  st_nxt.data = I_TXD;
               end else if (I_RD_POS) begin
                  // Comma was sent from positive, ends negative
                  st_nxt.data  = `CG_D5_6;
                  st_nxt.subst = 1'b1;
               end else begin
                  // Comma ended positive, D16.2 pulls it back
                  st_nxt.data  = `CG_D16_2;
                  st_nxt.subst = 1'b1;
               end
            end
         end
      endcase
   end

   // ==========================================================
   // State register

   // Outputs idle low at reset; gap counter starts at its minimum
   always_ff @(posedge I_REF_CLK or posedge I_RST) begin
      if (I_RST) begin
         st_r.data      <= 8'h00;
         st_r.ctrl      <= 1'b0;
         st_r.elec_idle <= 1'b0;
         st_r.det_go    <= 1'b0;
         st_r.subst     <= 1'b0;
         st_r.gst       <= tx_osm_pkg::GS_NORMAL;
         st_r.a_cnt     <= `A_GAP_MIN;
      end else begin
         st_r <= st_nxt;
      end
   end

   // ==========================================================
   // Outputs, straight from the state register
   assign O_DATA         = st_r.data;
   assign O_CTRL         = st_r.ctrl;
   assign O_SUBST        = st_r.subst;
   assign O_ELEC_IDLE    = st_r.elec_idle;
   assign O_RX_DETECT_GO = st_r.det_go;

endmodule
`default_nettype wire

// *** tb/pipe_ctl_model.sv ***
// Purpose: PIPE controller on the far side
// Assumes: Bench asks for idle and detection
// Notes:   Detection never runs without idle
`timescale 1ns/100ps
`default_nettype none
module pipe_ctl_model (
   // Requests from the bench
   input  wire logic i_idle,
   input  wire logic i_det,
   // Controls to the mapper
   output logic      o_force,
   output logic      o_req
);
   // Idle is held whenever detection is asked
   assign o_force = i_idle | i_det;
   assign o_req   = i_det;
endmodule
`default_nettype wire

// *** tb/tx_osm_properties.sv ***
// Purpose: Port properties of the mapper
// Assumes: One clock, reset high
// Notes:   One clock of latency on each path
`timescale 1ns/100ps
`default_nettype none
module tx_osm_properties (
   // Clock and reset
   input wire logic       I_REF_CLK,
   input wire logic       I_RST,
   // Mapper inputs
   input wire logic [1:0] I_MODE,
   input wire logic [7:0] I_TXD,
   input wire logic       I_TXC,
   input wire logic       I_TERM_COL,
   input wire logic       I_RD_POS,
   input wire logic       I_FORCE_ELEC_IDLE,
   input wire logic       I_RX_DETECT_REQ,
   // Mapper outputs
   input wire logic [7:0] O_DATA,
   input wire logic       O_CTRL,
   input wire logic       O_SUBST,
   input wire logic       O_ELEC_IDLE,
   input wire logic       O_RX_DETECT_GO
);
   // ====
   // Shared terms
   default clocking cb @(posedge I_REF_CLK); endclocking
   default disable iff (I_RST);
   wire xa_idle = I_MODE == 2'h2 && I_TXC && I_TXD == 8'h07;
   wire g_dat   = I_MODE == 2'h3 && !I_TXC;
   wire cfg     = I_TXD inside {8'hB5, 8'h42};
   sequence s_comma;
      I_MODE == 2'h3 && I_TXC && I_TXD == 8'hBC;
   endsequence
   // Properties
   a_bypass_pass: assert property (I_MODE == 2'h0 |=>
      O_DATA == $past(I_TXD) && O_CTRL == $past(I_TXC) && !O_SUBST)
      else $error("bypass");
   a_xaui_data: assert property (I_MODE == 2'h2 && !I_TXC |=>
      O_DATA == $past(I_TXD) && !O_CTRL) else $error("data");
   a_undef_ctrl: assert property (I_MODE == 2'h2 && I_TXC &&
      I_TXD == 8'h00 |=> O_CTRL && O_DATA == 8'hFE) else $error("undef");
   a_idle_set: assert property (xa_idle |=> O_CTRL && O_SUBST &&
      O_DATA inside {8'h1C, 8'h7C, 8'hBC}) else $error("idle");
   a_align_gap: assert property ($past(xa_idle) && O_DATA == 8'h7C
      |=> !($past(xa_idle) && O_DATA == 8'h7C) [*8]) else $error("gap");
   a_gige_idle: assert property (s_comma ##1 (g_dat && !cfg) |=>
      O_SUBST && O_DATA == ($past(I_RD_POS) ? 8'hC5 : 8'h50))
      else $error("idle set");
   a_cfg_pass: assert property (s_comma ##1 (g_dat && cfg) |=>
      !O_SUBST && O_DATA == $past(I_TXD)) else $error("config");
   a_elec_follow: assert property (I_MODE == 2'h1 |=>
      O_ELEC_IDLE == $past(I_FORCE_ELEC_IDLE) && O_RX_DETECT_GO ==
      ($past(I_FORCE_ELEC_IDLE) && $past(I_RX_DETECT_REQ)))
      else $error("pipe");
   a_elec_off: assert property (I_MODE != 2'h1 |=>
      !O_ELEC_IDLE && !O_RX_DETECT_GO) else $error("leak");
endmodule
bind tx_pcs_ordered_set_mapper tx_osm_properties tx_osm_properties_inst (.*);
`default_nettype wire

// *** tb/tx_pcs_ordered_set_mapper_tb_top.sv ***
// Purpose: Self-checking bench of the mapper
// Assumes: Seed 59
// Notes:   Expected groups come from predict
`timescale 1ns/100ps
`default_nettype none
module tx_pcs_ordered_set_mapper_tb_top;
   // ====
   // Signals and reference state
   logic        clk, rst, txc, term, rd, f_in, d_in, frc, req, comma;
   logic        o_ctrl, o_subst, o_ei, o_go;
   logic [1:0]  mode;
   logic [7:0]  txd, o_data;
   logic [11:0] exp;
   logic [6:0]  lf;
   logic [4:0]  cnt;
   int          failures, n_compared;
   logic [7:0]  ctl [11] = '{8'h9C, 8'hFB, 8'hFD, 8'hFE, 8'h1C, 8'h3C,
                             8'h5C, 8'h7C, 8'hBC, 8'hDC, 8'hF7};
   // Design and far side
   tx_pcs_ordered_set_mapper tx_pcs_ordered_set_mapper_inst (
      .I_REF_CLK(clk), .I_RST(rst), .I_MODE(mode), .I_TXD(txd),
      .I_TXC(txc), .I_TERM_COL(term), .I_RD_POS(rd),
      .I_FORCE_ELEC_IDLE(frc), .I_RX_DETECT_REQ(req), .O_DATA(o_data),
      .O_CTRL(o_ctrl), .O_SUBST(o_subst), .O_ELEC_IDLE(o_ei),
      .O_RX_DETECT_GO(o_go));
   pipe_ctl_model pipe_ctl_model_inst (.i_idle(f_in), .i_det(d_in),
      .o_force(frc), .o_req(req));
   // Clock of 20 ns
   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end
   // Compare and count
   task automatic check(string nm, logic [11:0] s, logic [11:0] e);
      n_compared++;
      if (s !== e) begin
         failures++;
         $display("[ERR] %s expected %h seen %h", nm, e, s);
      end
   endtask
   // Expected group for the character now on the inputs
   function automatic logic [11:0] predict();
      logic [7:0] d;
      logic       s, p;
      d = txd;
      s = 1'b0;
      p = mode == 2'h1 && frc;
      if (p) d = 8'h00;
      if (mode == 2'h2 && txc && txd == 8'h07) begin
         s = 1'b1;
         d = lf[6] ? 8'hBC : 8'h1C;
         if (cnt == 5'h00) d = 8'h7C;
         if (term) d = 8'hBC;
         if (cnt == 5'h00 && !term) cnt = 5'h10 + {1'b0, lf[3:0]};
         else if (cnt != 5'h00) cnt = cnt - 5'h01;
         lf = {lf[5:0], lf[6] ^ lf[5]};
      end else if (mode == 2'h2 && txc && !(txd inside {ctl})) d = 8'hFE;
      if (mode == 2'h3 && comma && !txc &&
          !(txd inside {8'hB5, 8'h42})) begin
         s = 1'b1;
         d = rd ? 8'hC5 : 8'h50;
      end
      comma = mode == 2'h3 && txc && txd == 8'hBC;
      return {d, txc && !p, s, p, p && req};
   endfunction
   // One character in, the previous group checked
   task automatic cyc(logic [1:0] m, logic [7:0] d, logic k);
      @(posedge clk);
      mode <= m;
      txd  <= d;
      txc  <= k;
      term <= $urandom_range(7) == 0;
      rd   <= 1'($urandom);
      f_in <= 1'($urandom);
      d_in <= $urandom_range(3) == 0;
      #1;
      check("group", {o_data, o_ctrl, o_subst, o_ei, o_go}, exp);
      exp = predict();
   endtask
   // Counts and verdict
   task automatic final_report();
      $display("compared %0d failures %0d", n_compared, failures);
      if (failures == 0 && n_compared > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   // Main sequence
   initial begin
      {mode, txd, txc, term, rd, f_in, d_in, comma} = '0;
      rst = 1'b1;
      exp = '0;
      lf = 7'h7F;
      cnt = 5'h10;
      failures = 0;
      n_compared = 0;
      void'($urandom(59));
      repeat (3) @(posedge clk);
      #1 check("reset", {o_data, o_ctrl, o_subst, o_ei, o_go}, '0);
      @(posedge clk);
      rst <= 1'b0;
      // Bypass, then PIPE with idle and detect requests
      for (int i = 0; i < 60; i++) cyc(2'(i / 30), 8'($urandom), 1'($urandom));
      $display("bypass and pipe done");
      // Control table, undefined codes, then idles among data
      foreach (ctl[i]) cyc(2'h2, ctl[i], 1'b1);
      cyc(2'h2, 8'h00, 1'b1);
      cyc(2'h2, 8'hFF, 1'b1);
      for (int i = 0; i < 120; i++) begin
         if ($urandom_range(4) == 0) cyc(2'h2, 8'($urandom), 1'b0);
         else cyc(2'h2, 8'h07, 1'b1);
      end
      $display("xaui done");
      // Commas followed by data, config data or control
      for (int i = 0; i < 80; i++) begin
         cyc(2'h3, 8'hBC, 1'b1);
         case ($urandom_range(3))
            0: cyc(2'h3, 8'hB5, 1'b0);
            1: cyc(2'h3, 8'h42, 1'b0);
            2: cyc(2'h3, 8'($urandom), 1'b1);
            default: cyc(2'h3, 8'($urandom), 1'b0);
         endcase
      end
      cyc(2'h0, 8'h00, 1'b0);
      $display("gige done");
      final_report();
   end
endmodule
`default_nettype wire
